/* File: inc/gddr_pkg.sv */
// Functional notes
// - Gearing ratios x2, x3.5, x4 and x5 between bit clock and word clock.
// - Words cross from the fast clock to the fabric clock inside the block.
// - Each lane yields twice the gearing ratio in word bits.
// - Consecutive bit pairs from bit zero each hold one DDR bit period, except in every second x3.5 word, where pairs straddle two periods.
// - Even bit of a pair is rising-edge data, odd bit falling-edge data, except every second x3.5 word, which starts on a falling bit.
// - Up to 32 lanes on the global network, 11 on the regional network.
// - Active-low async lane reset clears gearing logic; receive reset independent of transmit.
// - Toggling fast clock pause resets receive gearing and realigns the word pattern.
// - Toggling fast clock pause clears accumulated bit-slip adjustment.
// - Toggling fast clock pause also resets transmit gearing state machines; this block has no transmit side to reset.
// - Edge-aligned uses global or regional clock; center-aligned uses global only.
// - Fabric words indexed by input lane number, at most 32 lanes.
// - Rising edge of per-lane shift request moves that lane's word boundary.
package gddr_pkg;

    localparam int unsigned LANE_MAX      = 32;
    localparam int unsigned LANE_REG_MAX  = 11;
    localparam int unsigned WORD_MAX      = 10;
    localparam int unsigned HIST_W        = 22;
    localparam int unsigned CNT_W         = 4;
    localparam int unsigned OFF_W         = 4;
    localparam int unsigned SH_W          = 5;
    localparam int unsigned LANE_IDX_W    = 6;
    localparam int unsigned BUF_DEPTH     = 2;

    localparam logic [CNT_W-1:0] BITS_X2      = 4'h4;
    localparam logic [CNT_W-1:0] BITS_X3P5    = 4'h7;
    localparam logic [CNT_W-1:0] BITS_X4      = 4'h8;
    localparam logic [CNT_W-1:0] BITS_X5      = 4'hA;
    localparam logic [CNT_W-1:0] BITS_PER_CYC = 4'h2;
    localparam logic [1:0]       SETTLE_CYC   = 2'h3;

    typedef enum logic [1:0] {
        GDDR_GEAR_X2   = 2'h0,
        GDDR_GEAR_X3P5 = 2'h1,
        GDDR_GEAR_X4   = 2'h2,
        GDDR_GEAR_X5   = 2'h3
    } gddr_gear_t;

    typedef logic [WORD_MAX-1:0] gddr_word_t;

    // Word bits per lane for a gearing ratio
    function automatic logic [CNT_W-1:0] gddr_word_bits(input gddr_gear_t g);
        logic [CNT_W-1:0] b;
        case (g)
            GDDR_GEAR_X2:   b = BITS_X2;
            GDDR_GEAR_X3P5: b = BITS_X3P5;
            GDDR_GEAR_X4:   b = BITS_X4;
            GDDR_GEAR_X5:   b = BITS_X5;
            default:        b = BITS_X4;
        endcase
        return b;
    endfunction

    function automatic gddr_word_t gddr_word_mask(input logic [CNT_W-1:0] bits);
        gddr_word_t m;
        m = '0;
        for (int i = 0; i < WORD_MAX; i++) begin
            m[i] = (CNT_W'(i) < bits);
        end
        return m;
    endfunction

endpackage

/* File: design/gddr_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module gddr_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;

endmodule
`default_nettype wire

/* File: design/gddr_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module gddr_buf2 #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0] count_ff;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count_ff != CNT_W'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: design/gddr_deser.sv */
`timescale 1ns/1ps
`default_nettype none
module gddr_deser
    import gddr_pkg::*;
(
    // Fabric clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    // Link side
    input  wire logic                               bank_fast_clock_i,
    input  wire logic                               async_lane_reset_n_i,
    input  wire logic [LANE_MAX-1:0]                rx_data_i,
    // Static configuration
    input  wire logic [1:0]                         gear_mode_i,
    input  wire logic                               clk_net_global_i,
    input  wire logic                               center_aligned_i,
    // Fabric control
    input  wire logic                               fast_clock_pause_i,
    input  wire logic [LANE_MAX-1:0]                lane_word_shift_request_i,
    // Fabric words
    output logic      [LANE_MAX-1:0][WORD_MAX-1:0]  lane_fabric_word_o,
    output logic                                    word_valid_o,
    input  wire logic                               word_ready_i,
    // Status
    output logic                                    overflow_o,
    output logic                                    cfg_error_o
);

    localparam int unsigned FSYNC_W = 2 + 1 + LANE_MAX + 1;
    localparam int unsigned SSYNC_W = 3;
    localparam int unsigned FLAT_W  = LANE_MAX * WORD_MAX;

    ////////////////////////////////////////////////////////////////////////////////
    // Fast domain reset: asserted at once, released on the fast clock

    logic rst_fast_meta_ff;
    logic rst_fast_n_ff;

    always_ff @(posedge bank_fast_clock_i or negedge async_lane_reset_n_i) begin
        if (!async_lane_reset_n_i) begin
            rst_fast_meta_ff <= 1'b0;
            rst_fast_n_ff    <= 1'b0;
        end else begin
            rst_fast_meta_ff <= 1'b1;
            rst_fast_n_ff    <= rst_fast_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossing into the fast domain

    logic                ack_tgl_ff;
    logic [FSYNC_W-1:0]  fsync_q;
    gddr_gear_t          gear_s;
    logic                pause_s;
    logic [LANE_MAX-1:0] slip_s;
    logic                ack_s;

    // Gear mode is synchronised too; a change takes effect after a pause
    gddr_sync2 #(
        .WIDTH (FSYNC_W)
    ) u_fast_sync (
        .clk_i   (bank_fast_clock_i),
        .rst_n_i (rst_fast_n_ff),
        .d_i     ({gear_mode_i, fast_clock_pause_i, lane_word_shift_request_i, ack_tgl_ff}),
        .q_o     (fsync_q)
    );

    assign gear_s  = gddr_gear_t'(fsync_q[FSYNC_W-1 -: 2]);
    assign pause_s = fsync_q[LANE_MAX + 1];
    assign slip_s  = fsync_q[LANE_MAX:1];
    assign ack_s   = fsync_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Settling after fast reset

    logic [1:0] settle_ff;
    logic       armed;

    // Sync chain restarts at zero; edges seen before it refills are not real
    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            settle_ff <= '0;
        end else if (settle_ff != SETTLE_CYC) begin
            settle_ff <= settle_ff + 1'b1;
        end
    end

    assign armed = (settle_ff == SETTLE_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // DDR capture

    logic [LANE_MAX-1:0] rise_ff;
    logic [LANE_MAX-1:0] fall_ff;

    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            rise_ff <= '0;
        end else begin
            rise_ff <= rx_data_i;
        end
    end

    // Falling half-bit of the same period
    always_ff @(negedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            fall_ff <= '0;
        end else begin
            fall_ff <= rx_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Word boundary tracking

    gddr_gear_t       gear_ff;
    logic [CNT_W-1:0] wbits;
    logic [CNT_W-1:0] acc_ff;
    logic [CNT_W-1:0] acc_sum;
    logic [CNT_W-1:0] lo_bits;
    logic             emit;
    logic             pause_d_ff;
    logic             pause_evt;

    assign wbits     = gddr_word_bits(gear_ff);
    assign acc_sum   = acc_ff + BITS_PER_CYC;
    assign emit      = (acc_sum >= wbits);
    assign lo_bits   = emit ? (acc_sum - wbits) : '0;
    // Same event would realign a transmit side; none lives in this block
    assign pause_evt = armed && (pause_s ^ pause_d_ff);

    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            pause_d_ff <= 1'b0;
        end else begin
            pause_d_ff <= pause_s;
        end
    end

    // Gear taken only while settling or at a pause, never in mid-word
    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            gear_ff <= GDDR_GEAR_X2;
        end else if (!armed || pause_evt) begin
            gear_ff <= gear_s;
        end
    end

    // x3.5 emits every 3 or 4 cycles; the odd half-pair carries over
    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            acc_ff <= '0;
        end else if (pause_evt) begin
            acc_ff <= '0;
        end else if (emit) begin
            acc_ff <= lo_bits;
        end else begin
            acc_ff <= acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-lane history, slip offset and word extraction

    logic [LANE_MAX-1:0][HIST_W-1:0]   hist_ff;
    logic [LANE_MAX-1:0][OFF_W-1:0]    off_ff;
    logic [LANE_MAX-1:0]               slip_d_ff;
    logic [LANE_MAX-1:0][WORD_MAX-1:0] nxt_word;

    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            slip_d_ff <= '0;
        end else begin
            slip_d_ff <= slip_s;
        end
    end

    for (genvar l = 0; l < LANE_MAX; l++) begin : g_lane
        logic [HIST_W-1:0] nxt_hist;
        logic [OFF_W-1:0]  eff_off;
        logic [SH_W-1:0]   sh;
        logic [HIST_W-1:0] shifted;
        logic              slip_rise;

        // Oldest bit lands in word bit 0, rising half first
        assign nxt_hist  = {fall_ff[l], rise_ff[l], hist_ff[l][HIST_W-1:2]};
        assign eff_off   = (off_ff[l] >= wbits) ? '0 : off_ff[l];
        assign sh        = SH_W'(HIST_W) - SH_W'(wbits) - SH_W'(lo_bits) - SH_W'(eff_off);
        assign shifted   = nxt_hist >> sh;
        assign nxt_word[l] = shifted[WORD_MAX-1:0] & gddr_word_mask(wbits);
        assign slip_rise = armed && slip_s[l] && !slip_d_ff[l];

        always_ff @(posedge bank_fast_clock_i) begin
            if (!rst_fast_n_ff || pause_evt) begin
                hist_ff[l] <= '0;
            end else begin
                hist_ff[l] <= nxt_hist;
            end
        end

        always_ff @(posedge bank_fast_clock_i) begin
            if (!rst_fast_n_ff) begin
                off_ff[l] <= '0;
            end else if (pause_evt) begin
                off_ff[l] <= '0;
            end else if (slip_rise) begin
                off_ff[l] <= (eff_off == wbits - 1'b1) ? '0 : eff_off + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Word hand-off, fast side

    logic [LANE_MAX-1:0][WORD_MAX-1:0] xfer_word_ff;
    logic                              req_tgl_ff;
    logic                              ovf_tgl_ff;
    logic                              busy;

    assign busy = req_tgl_ff ^ ack_s;

    // Held stable while a request is open, so the fabric may read it directly
    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            xfer_word_ff <= '0;
            req_tgl_ff   <= 1'b0;
        end else if (emit && !busy && !pause_evt) begin
            xfer_word_ff <= nxt_word;
            req_tgl_ff   <= ~req_tgl_ff;
        end
    end

    // A word that finds the hand-off busy is dropped and reported
    always_ff @(posedge bank_fast_clock_i) begin
        if (!rst_fast_n_ff) begin
            ovf_tgl_ff <= 1'b0;
        end else if (emit && busy && !pause_evt) begin
            ovf_tgl_ff <= ~ovf_tgl_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crossing into the fabric domain

    logic [SSYNC_W-1:0] ssync_q;
    logic               req_s;
    logic               ovf_s;
    logic               lane_rst_s;
    logic               fab_rst_n;

    gddr_sync2 #(
        .WIDTH (SSYNC_W)
    ) u_fab_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({req_tgl_ff, ovf_tgl_ff, async_lane_reset_n_i}),
        .q_o     (ssync_q)
    );

    assign req_s      = ssync_q[2];
    assign ovf_s      = ssync_q[1];
    assign lane_rst_s = ssync_q[0];
    assign fab_rst_n  = rst_n_i && lane_rst_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Lane limit by clock network

    logic [FLAT_W-1:0] buf_in_data;
    logic              buf_in_valid;
    logic              buf_in_ready;
    logic [FLAT_W-1:0] buf_out_data;
    logic              cfg_error_ff;

    // Regional network limits lanes; center-aligned needs the global network
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_error_ff <= 1'b0;
        end else begin
            cfg_error_ff <= center_aligned_i && !clk_net_global_i;
        end
    end

    assign cfg_error_o = cfg_error_ff;

    for (genvar l = 0; l < LANE_MAX; l++) begin : g_limit
        logic lane_ok;
        assign lane_ok = clk_net_global_i || (l < LANE_REG_MAX);
        assign buf_in_data[l*WORD_MAX +: WORD_MAX] = lane_ok ? xfer_word_ff[l] : '0;
        assign lane_fabric_word_o[l] = buf_out_data[l*WORD_MAX +: WORD_MAX];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Word hand-off, fabric side

    logic req_seen_ff;
    logic ovf_seen_ff;
    logic overflow_ff;

    assign buf_in_valid = (req_s != req_seen_ff);

    // A full buffer holds the ack back, which keeps the hand-off busy so the fast side drops words
    always_ff @(posedge clk_i) begin
        if (!fab_rst_n) begin
            req_seen_ff <= 1'b0;
            ack_tgl_ff  <= 1'b0;
        end else if (buf_in_valid && buf_in_ready) begin
            req_seen_ff <= req_s;
            ack_tgl_ff  <= req_s;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!fab_rst_n) begin
            ovf_seen_ff <= 1'b0;
            overflow_ff <= 1'b0;
        end else begin
            ovf_seen_ff <= ovf_s;
            if (ovf_s != ovf_seen_ff) begin
                overflow_ff <= 1'b1;
            end
        end
    end

    assign overflow_o = overflow_ff;

    gddr_buf2 #(
        .WIDTH (FLAT_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_n_i     (fab_rst_n),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_data),
        .out_valid_o (word_valid_o),
        .out_ready_i (word_ready_i),
        .out_data_o  (buf_out_data)
    );

endmodule
`default_nettype wire

/* File: sim/gddr_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gddr_link_model
    import gddr_pkg::*;
(
    // Forwarded link
    output logic                fast_clk_o,
    output logic [LANE_MAX-1:0] data_o,
    // Per-lane bit values
    input  wire logic [LANE_MAX-1:0] rise_i,
    input  wire logic [LANE_MAX-1:0] fall_i
);
    // Free running, phase offset from the fabric clock
    initial begin
        fast_clk_o = 1'b0;
        data_o     = '0;
        #3;
        forever #6 fast_clk_o = ~fast_clk_o;
    end

    // Centred data: each bit settles mid-way to its sampling edge
    always @(negedge fast_clk_o) data_o <= #3 rise_i;
    always @(posedge fast_clk_o) data_o <= #3 fall_i;
endmodule
`default_nettype wire

/* File: sim/gddr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module gddr_monitor
    import gddr_pkg::*;
(
    // Clock and reset
    input wire logic                             clk_i,
    input wire logic                             rst_n_i,
    // Configuration
    input wire logic [1:0]                       gear_mode_i,
    input wire logic                             clk_net_global_i,
    input wire logic                             center_aligned_i,
    // Fabric side
    input wire logic [LANE_MAX-1:0][WORD_MAX-1:0] lane_fabric_word_o,
    input wire logic                             word_valid_o,
    input wire logic                             word_ready_i,
    input wire logic                             overflow_o,
    input wire logic                             cfg_error_o
);
    default clocking cb @(posedge clk_i); endclocking

    logic [3:0] nbits;
    logic       hi_bits;

    ////////////////////////////////////////////////////////////////
    // Any bit above twice the ratio set in any lane
    always_comb begin
        case (gear_mode_i)
            2'h0:    nbits = 4'h4;
            2'h1:    nbits = 4'h7;
            2'h2:    nbits = 4'h8;
            default: nbits = 4'hA;
        endcase
        hi_bits = 1'b0;
        for (int l = 0; l < LANE_MAX; l++) begin
            for (int b = 0; b < WORD_MAX; b++) begin
                if (b >= nbits) hi_bits = hi_bits | lane_fabric_word_o[l][b];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    cfg_err_a: assert property (disable iff (!rst_n_i) $past(rst_n_i) |->
        cfg_error_o == ($past(center_aligned_i) && !$past(clk_net_global_i)))
        else $error("config error flag wrong");
    reset_valid_a: assert property (!rst_n_i |=> !word_valid_o)
        else $error("word valid after reset");
    reset_ovf_a: assert property (!rst_n_i ##1 1'b1 |-> !overflow_o)
        else $error("overflow after reset");
    ovf_sticky_a: assert property (disable iff (!rst_n_i) overflow_o |=> overflow_o)
        else $error("overflow flag dropped");
    hold_word_a: assert property (disable iff (!rst_n_i)
        word_valid_o && !word_ready_i |=> word_valid_o && $stable(lane_fabric_word_o))
        else $error("stalled word not held");
    region_mask_a: assert property (disable iff (!rst_n_i)
        word_valid_o && !clk_net_global_i |-> lane_fabric_word_o[LANE_MAX-1:LANE_REG_MAX] == '0)
        else $error("regional lane not zero");
    width_mask_a: assert property (disable iff (!rst_n_i) word_valid_o |-> !hi_bits)
        else $error("bits above word width set");
    first_word_a: assert property (disable iff (!rst_n_i) $rose(rst_n_i) |-> ##[1:40] word_valid_o)
        else $error("no word after reset");

    handshake_c: cover property (word_valid_o && word_ready_i);
    overflow_c:  cover property ($rose(overflow_o));
    regional_c:  cover property (word_valid_o && !clk_net_global_i);
endmodule

bind gddr_deser gddr_monitor i_gddr_monitor (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .gear_mode_i        (gear_mode_i),
    .clk_net_global_i   (clk_net_global_i),
    .center_aligned_i   (center_aligned_i),
    .lane_fabric_word_o (lane_fabric_word_o),
    .word_valid_o       (word_valid_o),
    .word_ready_i       (word_ready_i),
    .overflow_o         (overflow_o),
    .cfg_error_o        (cfg_error_o)
);
`default_nettype wire

/* File: sim/test_gddr_deser.sv */
`timescale 1ns/1ps
`default_nettype none
module test_gddr_deser;
    import gddr_pkg::*;

    typedef struct {
        logic [1:0] gear;
        logic       glob;
        logic       ctr;
        logic       alt;
        logic       err;
    } gddr_row_t;

    logic                             clk_i = 1'b0;
    logic                             rst_n_i, async_n, pause, glob, ctr, ready;
    logic                             fclk, cfg_err, valid, ovf;
    logic [1:0]                       gear;
    logic [LANE_MAX-1:0]              rx, req, rise, fall;
    logic [LANE_MAX-1:0][WORD_MAX-1:0] words;
    int                               fails = 0;
    int                               comparisons = 0;
    gddr_row_t                        cur;
    gddr_row_t rows [5] = '{'{2'h0, 1'b1, 1'b0, 1'b1, 1'b0}, '{2'h1, 1'b1, 1'b1, 1'b0, 1'b0},
                            '{2'h2, 1'b1, 1'b0, 1'b1, 1'b0}, '{2'h3, 1'b0, 1'b1, 1'b1, 1'b1},
                            '{2'h2, 1'b0, 1'b0, 1'b0, 1'b0}};

    always #12.5 clk_i = ~clk_i;

    gddr_link_model i_gddr_link_model (.fast_clk_o(fclk), .data_o(rx), .rise_i(rise),
                                       .fall_i(fall));

    gddr_deser i_gddr_deser (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .bank_fast_clock_i(fclk),
        .async_lane_reset_n_i(async_n), .rx_data_i(rx), .gear_mode_i(gear),
        .clk_net_global_i(glob), .center_aligned_i(ctr), .fast_clock_pause_i(pause),
        .lane_word_shift_request_i(req), .lane_fabric_word_o(words), .word_valid_o(valid),
        .word_ready_i(ready), .overflow_o(ovf), .cfg_error_o(cfg_err));

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_word(int l, gddr_word_t got, gddr_word_t exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t lane %0d word %h expected %h", $time, l, got, exp);
        end
    endtask

    task automatic chk_flag(string what, logic got, logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s is %b expected %b", $time, what, got, exp);
        end
    endtask

    // Even word bits carry the rising sample, odd bits the falling one; sw swaps them
    function automatic gddr_word_t exp_word(int l, logic sw);
        gddr_word_t w;
        logic       rb, fb;
        int         n;
        n  = cur.gear == 2'h0 ? 4 : cur.gear == 2'h1 ? 7 : cur.gear == 2'h2 ? 8 : 10;
        rb = sw ? fall[l] : rise[l];
        fb = sw ? rise[l] : fall[l];
        w  = '0;
        for (int i = 0; i < n; i++) w[i] = (i % 2 == 0) ? rb : fb;
        if (!cur.glob && l >= LANE_REG_MAX) w = '0;
        return w;
    endfunction

    // Odd ratio alternates pair alignment, so that row carries constant lanes
    task automatic apply(gddr_row_t r);
        cur = r;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        async_n <= 1'b0;
        gear    <= r.gear;
        glob    <= r.glob;
        ctr     <= r.ctr;
        req     <= '0;
        for (int l = 0; l < LANE_MAX; l++) begin
            rise[l] <= r.alt ? (l % 3 != 1) : (l % 2 == 0);
            fall[l] <= r.alt ? (l % 3 != 0) : (l % 2 == 0);
        end
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        async_n <= 1'b1;
    endtask

    task automatic take(int n, logic check, logic [LANE_MAX-1:0] sw);
        int got;
        int k;
        got = 0;
        k   = 0;
        while (got < n) begin
            @(negedge clk_i);
            k++;
            if (k > 400) begin
                fails++;
                report_and_stop();
            end
            if (valid === 1'b1) begin
                got++;
                for (int l = 0; l < LANE_MAX; l++) begin
                    if (check) chk_word(l, words[l], exp_word(l, sw[l]));
                end
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {rst_n_i, async_n, pause, glob, ctr, gear} = '0;
        {req, rise, fall} = '0;
        ready = 1'b1;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk_flag("valid in reset", valid, 1'b0);
        chk_flag("overflow in reset", ovf, 1'b0);
        foreach (rows[i]) begin
            apply(rows[i]);
            take(6, 1'b0, '0);
            take(4, 1'b1, '0);
            chk_flag("config error", cfg_err, rows[i].err);
        end
        // Fabric stall: buffer fills, hand-off backs up and drops words
        apply(rows[2]);
        @(negedge clk_i);
        chk_flag("valid after reset", valid, 1'b0);
        chk_flag("overflow after reset", ovf, 1'b0);
        take(4, 1'b0, '0);
        @(posedge clk_i) ready <= 1'b0;
        repeat (40) @(posedge clk_i);
        @(negedge clk_i);
        chk_flag("valid while stalled", valid, 1'b1);
        chk_flag("overflow", ovf, 1'b1);
        @(posedge clk_i) ready <= 1'b1;
        take(6, 1'b0, '0);
        take(3, 1'b1, '0);
        // One slip on lane 0 swaps its pairs, other lanes untouched
        @(posedge clk_i) req[0] <= 1'b1;
        repeat (30) @(posedge clk_i);
        take(6, 1'b0, '0);
        take(3, 1'b1, 32'h0000_0001);
        @(posedge clk_i);
        req[0] <= 1'b0;
        pause  <= ~pause;
        repeat (30) @(posedge clk_i);
        take(6, 1'b0, '0);
        take(3, 1'b1, '0);
        report_and_stop();
    end
endmodule
`default_nettype wire
